// ===== rtl/dam_consts.vh
`ifndef DAM_CONSTS_VH
`define DAM_CONSTS_VH

// ****************************************
// Alarm source indices
// ****************************************
`define DAM_N_SRC 9
`define DAM_SRC_HEAT 0
`define DAM_SRC_OVOLT 1
`define DAM_SRC_OSPD 2
`define DAM_SRC_OCUR 3
`define DAM_SRC_UVOLT 4
`define DAM_SRC_BRAKE 5
`define DAM_SRC_CAP 6
`define DAM_SRC_STORE 7
`define DAM_SRC_CPUP 8
// Sources clearable by the clear edge (brake taken as clearable)
`define DAM_CLR_MASK 9'h035

// ****************************************
// Blink counts
// ****************************************
`define DAM_BL_HEAT 4'h2
`define DAM_BL_OVOLT 4'h3
`define DAM_BL_OSPD 4'h4
`define DAM_BL_OCUR 4'h5
`define DAM_BL_UVOLT 4'h6
`define DAM_BL_BRAKE 4'h7
`define DAM_BL_NINE 4'h9
`define DAM_BL_NONE 4'h0

// ****************************************
// Timing in ms and in clock cycles
// ****************************************
`define DAM_CLK_HZ 50000000
`define DAM_ON_MS 200
`define DAM_OFF_MS 200
`define DAM_GAP_MS 1400
`define DAM_GAP_LONG_MS 3000
`define DAM_ON_CYC (`DAM_ON_MS * (`DAM_CLK_HZ / 1000))
`define DAM_OFF_CYC (`DAM_OFF_MS * (`DAM_CLK_HZ / 1000))
`define DAM_GAP_CYC (`DAM_GAP_MS * (`DAM_CLK_HZ / 1000))
`define DAM_GAP_LONG_CYC (`DAM_GAP_LONG_MS * (`DAM_CLK_HZ / 1000))
`endif

// ===== rtl/dam_blinker.v
`timescale 1ns/1ns
`include "dam_consts.vh"
module dam_blinker #(
  parameter ON_CYC = `DAM_ON_CYC,
  parameter OFF_CYC = `DAM_OFF_CYC,
  parameter GAP_CYC = `DAM_GAP_CYC,
  parameter GAP_LONG_CYC = `DAM_GAP_LONG_CYC
) (
  input wire clk,
  input wire rst,
  input wire [3:0] count,
  input wire long_gap,
  input wire steady,
  output reg lamp
);
  // ****************************************
  // Group sequencer
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_ON = 2'h1;
  localparam S_OFF = 2'h2;
  localparam S_GAP = 2'h3;
  reg [1:0] state_reg;
  reg [31:0] tmr_reg;
  reg [3:0] cnt_reg;
  wire [31:0] on_c = ON_CYC;
  wire [31:0] off_c = OFF_CYC;
  wire [31:0] gap_c = long_gap ? GAP_LONG_CYC : GAP_CYC;
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      tmr_reg <= 32'h0;
      cnt_reg <= 4'h0;
      lamp <= 1'b0;
    end else if (steady) begin
      state_reg <= S_IDLE;
      lamp <= 1'b1;
    end else begin
      tmr_reg <= tmr_reg + 32'h1;
      case (state_reg)
        S_IDLE: begin
          lamp <= 1'b0;
          tmr_reg <= 32'h0;
          if (count != `DAM_BL_NONE) begin
            state_reg <= S_ON;
            cnt_reg <= 4'h1;
            lamp <= 1'b1;
          end
        end
        S_ON: begin
          if (tmr_reg >= on_c - 32'h1) begin
            state_reg <= S_OFF;
            tmr_reg <= 32'h0;
            lamp <= 1'b0;
          end
        end
        S_OFF: begin
          if (tmr_reg >= off_c - 32'h1) begin
            tmr_reg <= 32'h0;
            if (cnt_reg >= count) begin
              state_reg <= S_GAP;
            end else begin
              state_reg <= S_ON;
              cnt_reg <= cnt_reg + 4'h1;
              lamp <= 1'b1;
            end
          end
        end
        default: begin
          // Longer pause set apart one nine-blink cause
          if (tmr_reg >= gap_c - 32'h1) begin
            state_reg <= S_IDLE;
            tmr_reg <= 32'h0;
          end
        end
      endcase
    end
  end
endmodule

// ===== rtl/dam_top.v
`timescale 1ns/1ns
`include "dam_consts.vh"
module dam_top #(
  parameter ON_CYC = `DAM_ON_CYC,
  parameter OFF_CYC = `DAM_OFF_CYC,
  parameter GAP_CYC = `DAM_GAP_CYC,
  parameter GAP_LONG_CYC = `DAM_GAP_LONG_CYC
) (
  input wire clk,
  input wire rst,
  input wire [`DAM_N_SRC-1:0] fault_detect,
  input wire cpu_error,
  input wire fault_clear_in,
  output wire fault_signal_out,
  output wire motor_current_en,
  output wire fault_indicator_lamp,
  output wire [`DAM_N_SRC-1:0] fault_latched
);
  // ****************************************
  // Clear edge detection
  // ****************************************
  reg clr_d_reg;
  reg cpu_reg;
  reg [`DAM_N_SRC-1:0] lat_reg;
  wire clr_edge = fault_clear_in & ~clr_d_reg;
  wire [`DAM_N_SRC-1:0] clr_mask = `DAM_CLR_MASK;
  // ****************************************
  // Latches, one per source
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `DAM_N_SRC; i = i + 1) begin : g_lat
      // Set wins over a clear edge in the same cycle
      always @(posedge clk) begin
        if (rst) begin
          lat_reg[i] <= 1'b0;
        end else if (fault_detect[i]) begin
          lat_reg[i] <= 1'b1;
        end else if (clr_edge && clr_mask[i]) begin
          lat_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always @(posedge clk) begin
    if (rst) begin
      clr_d_reg <= 1'b1;
      cpu_reg <= 1'b0;
    end else begin
      clr_d_reg <= fault_clear_in;
      if (cpu_error) begin
        cpu_reg <= 1'b1;
      end
    end
  end
  // ****************************************
  // Output and blink class
  // ****************************************
  reg ok_reg;
  always @(posedge clk) begin
    if (rst) begin
      ok_reg <= 1'b0;
    end else begin
      ok_reg <= ~((|lat_reg) | cpu_reg | (|fault_detect) | cpu_error);
    end
  end
  assign fault_signal_out = ok_reg;
  assign motor_current_en = ok_reg;
  assign fault_latched = lat_reg;
  reg [3:0] bl_count;
  // Lowest index wins when several are latched
  always @* begin
    bl_count = `DAM_BL_NONE;
    if (lat_reg[`DAM_SRC_HEAT]) begin
      bl_count = `DAM_BL_HEAT;
    end else if (lat_reg[`DAM_SRC_OVOLT]) begin
      bl_count = `DAM_BL_OVOLT;
    end else if (lat_reg[`DAM_SRC_OSPD]) begin
      bl_count = `DAM_BL_OSPD;
    end else if (lat_reg[`DAM_SRC_OCUR]) begin
      bl_count = `DAM_BL_OCUR;
    end else if (lat_reg[`DAM_SRC_UVOLT]) begin
      bl_count = `DAM_BL_UVOLT;
    end else if (lat_reg[`DAM_SRC_BRAKE]) begin
      bl_count = `DAM_BL_BRAKE;
    end else if (lat_reg[`DAM_SRC_CAP] | lat_reg[`DAM_SRC_STORE] |
                 lat_reg[`DAM_SRC_CPUP]) begin
      bl_count = `DAM_BL_NINE;
    end
  end
  wire long_gap = lat_reg[`DAM_SRC_CPUP] &
                  ~lat_reg[`DAM_SRC_CAP] & ~lat_reg[`DAM_SRC_STORE] &
                  (bl_count == `DAM_BL_NINE);
  dam_blinker #(
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GAP_CYC(GAP_CYC),
    .GAP_LONG_CYC(GAP_LONG_CYC)
  ) u_blink (
    .clk(clk),
    .rst(rst),
    .count(bl_count),
    .long_gap(long_gap),
    .steady(cpu_reg),
    .lamp(fault_indicator_lamp)
  );
endmodule

// ===== bench/dam_properties.sv
`timescale 1ns/1ns
`include "dam_consts.vh"
module dam_properties #(
  parameter ON_CYC = 4
) (
  input wire clk,
  input wire rst,
  input wire [`DAM_N_SRC-1:0] fault_detect,
  input wire cpu_error,
  input wire fault_clear_in,
  input wire fault_signal_out,
  input wire motor_current_en,
  input wire fault_indicator_lamp,
  input wire [`DAM_N_SRC-1:0] fault_latched
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_off; |fault_latched |-> !fault_signal_out; endproperty
  a_off: assert property (p_off) else $error("out on with alarm");
  property p_cur;
    (|fault_detect || cpu_error) |=> !motor_current_en && !fault_signal_out;
  endproperty
  a_cur: assert property (p_cur) else $error("current vs out");
  property p_set; fault_detect[0] |=> fault_latched[0]; endproperty
  a_set: assert property (p_set) else $error("heat not latched");
  property p_hold;
    (~$past(fault_latched) | fault_latched | `DAM_CLR_MASK) == 9'h1FF;
  endproperty
  a_hold: assert property (p_hold) else $error("fixed alarm lost");
  property p_clr;
    $rose(fault_clear_in) && fault_detect == 0
      |=> (fault_latched & `DAM_CLR_MASK) == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear edge failed");
  property p_lvl;
    fault_clear_in && $past(fault_clear_in)
      |=> (~fault_latched & $past(fault_latched)) == 0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level cleared");
  // Steady lamp of a CPU error would break the blink shape
  property p_on;
    disable iff (rst || cpu_error) $rose(fault_indicator_lamp)
      |-> fault_indicator_lamp [*4] ##1 !fault_indicator_lamp;
  endproperty
  a_on: assert property (p_on) else $error("blink length");
  property p_cpu;
    $past(cpu_error, 3) |-> fault_indicator_lamp && !fault_signal_out;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu lamp not lit");
endmodule
bind dam_top dam_properties #(.ON_CYC(ON_CYC)) u_props (.clk(clk),
  .rst(rst), .fault_detect(fault_detect), .cpu_error(cpu_error),
  .fault_clear_in(fault_clear_in), .fault_signal_out(fault_signal_out),
  .motor_current_en(motor_current_en),
  .fault_indicator_lamp(fault_indicator_lamp),
  .fault_latched(fault_latched));

// ===== bench/dam_host.sv
`timescale 1ns/1ns
// ****
// Host side of the clear input
// ****
module dam_host (
  input wire clk,
  output reg fault_clear_in
);
  // Starts ON so power-up gives no clear edge
  initial fault_clear_in = 1'b1;
  task clear_pulse;
    begin
      @(negedge clk);
      fault_clear_in = 1'b0;
      repeat (2) @(negedge clk);
      fault_clear_in = 1'b1;
    end
  endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
`include "dam_consts.vh"
`define CHK(n, e, g) compares += 1; if ((g) !== (e)) begin fail_count += 1; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end
module testbench;
  // ****
  // Stimulus and checks
  // ****
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [`DAM_N_SRC-1:0] fault_detect = 9'h000;
  reg cpu_error = 1'b0;
  reg [`DAM_N_SRC-1:0] exp_q, d;
  wire fault_clear_in, fault_signal_out, motor_current_en, lamp;
  wire [`DAM_N_SRC-1:0] fault_latched;
  integer fail_count = 0, compares = 0, seed = 88504, s, cnt, off, last, gap;
  always #10 clk = ~clk;
  dam_host host (.clk(clk), .fault_clear_in(fault_clear_in));
  // Short counts keep a nine-blink group near a hundred cycles
  dam_top #(.ON_CYC(4), .OFF_CYC(4), .GAP_CYC(10), .GAP_LONG_CYC(20)) DUT (
    .clk(clk), .rst(rst), .fault_detect(fault_detect),
    .cpu_error(cpu_error), .fault_clear_in(fault_clear_in),
    .fault_signal_out(fault_signal_out),
    .motor_current_en(motor_current_en),
    .fault_indicator_lamp(lamp), .fault_latched(fault_latched));
  function integer blinks(input integer k);
    blinks = (k < 6) ? k + 2 : 9;
  endfunction
  function clr(input integer k);
    clr = (k == 0 || k == 2 || k == 4 || k == 5);
  endfunction
  task do_reset;
    begin
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
    end
  endtask
  task test_done;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    for (s = 0; s < 9; s = s + 1) begin
      do_reset;
      fault_detect = 9'h001 << s;
      @(negedge clk);
      fault_detect = 9'h000;
      @(negedge clk);
      `CHK("latched", 9'h001 << s, fault_latched)
      `CHK("out", 1'b0, fault_signal_out)
      `CHK("current", 1'b0, motor_current_en)
      cnt = 0;
      off = 0;
      last = 0;
      gap = 0;
      repeat (260) begin
        @(negedge clk);
        if (lamp !== 1'b1) off = off + 1;
        else if (off > 0) begin
          if (off > 12) begin
            last = cnt;
            gap = off;
            cnt = 0;
          end
          cnt = cnt + 1;
          off = 0;
        end
      end
      `CHK("group", blinks(s), last)
      `CHK("long gap", s == 8, gap > 18)
      host.clear_pulse;
      repeat (3) @(negedge clk);
      `CHK("cleared", clr(s) ? 9'h000 : 9'h001 << s, fault_latched)
      `CHK("out", clr(s), fault_signal_out)
      `CHK("current", clr(s), motor_current_en)
    end
    do_reset;
    exp_q = 9'h000;
    repeat (12) begin
      d = $random(seed);
      fault_detect = d;
      @(negedge clk);
      fault_detect = 9'h000;
      exp_q = exp_q | d;
      @(negedge clk);
      `CHK("rand latched", exp_q, fault_latched)
      if (d[0]) begin
        host.clear_pulse;
        repeat (3) @(negedge clk);
        exp_q = exp_q & ~`DAM_CLR_MASK;
        `CHK("rand clear", exp_q, fault_latched)
      end
    end
    cpu_error = 1'b1;
    repeat (20) @(negedge clk);
    `CHK("cpu out", 1'b0, fault_signal_out)
    `CHK("cpu current", 1'b0, motor_current_en)
    host.clear_pulse;
    repeat (3) @(negedge clk);
    `CHK("cpu lamp", 1'b1, lamp)
    cpu_error = 1'b0;
    do_reset;
    @(negedge clk);
    `CHK("power cycle", 1'b0, lamp)
    `CHK("power latched", 9'h000, fault_latched)
    `CHK("power out", 1'b1, fault_signal_out)
    `CHK("power current", 1'b1, motor_current_en)
    test_done;
  end
endmodule
